// ---- design/cca_attach_fsm.sv ----
// Accessory, debug and charge-through attach states of the port machine.
// Assumes CC decoders and VBUS/VCONN comparators are clock synchronous.
`timescale 1ns/100ps
`default_nettype none
module cca_attach_fsm #(
   parameter int AME_CYCLES = cca_pkg::AME_CYC,
   parameter int DRP_SNK_CYCLES = cca_pkg::DRP_SNK_CYC,
   parameter int DRP_TRANS_CYCLES = cca_pkg::DRP_TRANS_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enterUdbgSrc,
   input wire logic enterDbgSnk,
   input wire logic enterPwrAcc,
   input wire logic enterCtUnatt,
   input wire logic isDrp,
   input wire logic ctSupport,
   input wire logic adv3a0,
   input wire logic cc1Open,
   input wire logic cc2Open,
   input wire logic cc1Rd,
   input wire logic cc2Rd,
   input wire logic ctCc1Rp,
   input wire logic ctCc2Rp,
   input wire logic ctCc1Open,
   input wire logic ctCc2Open,
   input wire logic orientNeeded,
   input wire logic orientFound,
   input wire logic vbusPresent,
   input wire logic vbusSafe5v,
   input wire logic vconnLow,
   input wire logic notPwrAcc,
   input wire logic altModeDone,
   input wire logic ctIdentity,
   input wire logic sopPrimeBusy,
   input wire logic ctDirected,
   output logic cc1PullUp,
   output logic cc2PullUp,
   output logic cc1PullDown,
   output logic cc2PullDown,
   output logic [1:0] advCurrent,
   output logic vbusOn,
   output logic vconnCc1,
   output logic vconnCc2,
   output logic dbgCommonEn,
   output logic dbgOrientEn,
   output logic pdEnable,
   output logic pdSrcDfp,
   output logic pdSopPrimeOnly,
   output logic hostIsolate,
   output logic hostCcPullUp,
   output logic ctCc1PullDown,
   output logic ctCc2PullDown,
   output logic flipped,
   output logic [2:0] exitCode,
   output logic exitValid
);
   cca_pkg::cca_state_t state_q, state_d;
   cca_pkg::cca_exit_t exit_d, pendExit_q;
   logic flip_q;
   logic timLoad, timExp;
   logic [cca_pkg::CNT_W-1:0] timCount;
   logic ctOpenCnt, ctOpenExp;
   logic [cca_pkg::CNT_W-1:0] ctCnt_q;
   logic ctArmed_q;
   logic [cca_pkg::CNT_W-1:0] trCnt_q;
   logic monOpen, ctOneRp;

   assign monOpen = flip_q ? cc2Open : cc1Open;
   assign ctOneRp = ctCc1Rp ^ ctCc2Rp;

   // both CT pins open for the sink share
   always_ff @(posedge clk) begin
      if (rst || state_q != cca_pkg::ST_CT_UNATT || !(ctCc1Open && ctCc2Open)) begin
         ctCnt_q <= '0;
      end else if (ctCnt_q != DRP_SNK_CYCLES[cca_pkg::CNT_W-1:0]) begin
         ctCnt_q <= ctCnt_q + 1'b1;
      end
   end
   assign ctOpenExp = (ctCnt_q == DRP_SNK_CYCLES[cca_pkg::CNT_W-1:0]);
   assign ctOpenCnt = ctOpenExp || ctDirected;
   always_ff @(posedge clk) begin
      if (rst || state_q != cca_pkg::ST_CT_UNATT || !ctOpenCnt) begin
         ctArmed_q <= 1'b0;
         trCnt_q <= '0;
      end else begin
         ctArmed_q <= 1'b1;
         trCnt_q <= trCnt_q + 1'b1;
      end
   end

   always_comb begin
      timLoad = 1'b0;
      timCount = '0;
      if (state_q != cca_pkg::ST_PWR_ACC && state_d == cca_pkg::ST_PWR_ACC) begin
         timLoad = 1'b1;
         timCount = AME_CYCLES[cca_pkg::CNT_W-1:0];
      end else if (state_q == cca_pkg::ST_PWR_ACC &&
                   state_d == cca_pkg::ST_VCONN_OFF) begin
         timLoad = 1'b1;
         timCount = cca_pkg::VCONN_OFF_CYC[cca_pkg::CNT_W-1:0];
      end
   end

   cca_timer u_timer (
      .clk(clk),
      .rst(rst),
      .load(timLoad),
      .count(timCount),
      .run(state_q == cca_pkg::ST_PWR_ACC),
      .expired(timExp)
   );

   always_comb begin
      state_d = state_q;
      exit_d = cca_pkg::EX_NONE;
      case (state_q)
         cca_pkg::ST_IDLE: begin
            if (enterUdbgSrc) begin
               state_d = cca_pkg::ST_UDBG_SRC;
            end else if (enterDbgSnk) begin
               state_d = cca_pkg::ST_DBG_SNK;
            end else if (enterPwrAcc) begin
               state_d = cca_pkg::ST_PWR_ACC;
            end else if (enterCtUnatt) begin
               state_d = cca_pkg::ST_CT_UNATT;
            end
         end
         cca_pkg::ST_UDBG_SRC, cca_pkg::ST_ODBG_SRC: begin
            if (cc1Open || cc2Open) begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = isDrp ? cca_pkg::EX_UNATT_SNK : cca_pkg::EX_UNATT_SRC;
            end else if (state_q == cca_pkg::ST_UDBG_SRC &&
                         orientNeeded && orientFound) begin
               state_d = cca_pkg::ST_ODBG_SRC;
            end
         end
         cca_pkg::ST_DBG_SNK: begin
            if (!vbusPresent) begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = cca_pkg::EX_UNATT_SNK;
            end
         end
         cca_pkg::ST_PWR_ACC: begin
            if (monOpen) begin
               state_d = cca_pkg::ST_VCONN_OFF;
               exit_d = cca_pkg::EX_UNATT_SNK;
            end else if (ctSupport && ctIdentity && !sopPrimeBusy) begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = cca_pkg::EX_CT_UNATT_SNK;
            end else if (notPwrAcc) begin
               state_d = cca_pkg::ST_VCONN_OFF;
               exit_d = cca_pkg::EX_TRY_SNK;
            end else if (timExp && !altModeDone) begin
               state_d = cca_pkg::ST_VCONN_OFF;
            end
         end
         cca_pkg::ST_VCONN_OFF: begin
            if (pendExit_q == cca_pkg::EX_NONE) begin
               state_d = cca_pkg::ST_UNSUP_ACC;
            end else begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = pendExit_q;
            end
         end
         cca_pkg::ST_UNSUP_ACC: begin
            if (monOpen) begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = cca_pkg::EX_UNATT_SNK;
            end
         end
         cca_pkg::ST_CT_UNATT: begin
            // VCONN lost wins, else one Rp
            if (vconnLow) begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = cca_pkg::EX_UNATT_SNK;
            end else if (ctOneRp) begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = cca_pkg::EX_CT_AWAIT;
            end else if (ctArmed_q) begin
               state_d = cca_pkg::ST_IDLE;
               exit_d = cca_pkg::EX_CT_UNSUP;
            end
         end
         default: begin
            state_d = cca_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= cca_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Exit held while VCONN is turned off; reported one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         pendExit_q <= cca_pkg::EX_NONE;
      end else if (state_d == cca_pkg::ST_VCONN_OFF &&
                   state_q == cca_pkg::ST_PWR_ACC) begin
         pendExit_q <= exit_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         exitValid <= 1'b0;
         exitCode <= 3'h0;
      end else begin
         exitValid <= (exit_d != cca_pkg::EX_NONE) &&
                      (state_d != cca_pkg::ST_VCONN_OFF);
         exitCode <= (state_d == cca_pkg::ST_VCONN_OFF) ? 3'h0 : exit_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flip_q <= 1'b0;
      end else if (state_q == cca_pkg::ST_IDLE &&
                   state_d == cca_pkg::ST_PWR_ACC) begin
         flip_q <= cc2Rd && !cc1Rd;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         flipped <= 1'b0;
      end else begin
         flipped <= flip_q;
      end
   end

   // Terminations and power switches from the next state
   always_ff @(posedge clk) begin
      if (rst) begin
         cc1PullUp <= 1'b0;
         cc2PullUp <= 1'b0;
         cc1PullDown <= 1'b0;
         cc2PullDown <= 1'b0;
         advCurrent <= cca_pkg::ADV_OFF;
         vbusOn <= 1'b0;
         vconnCc1 <= 1'b0;
         vconnCc2 <= 1'b0;
      end else begin
         cc1PullUp <= 1'b0;
         cc2PullUp <= 1'b0;
         cc1PullDown <= 1'b0;
         cc2PullDown <= 1'b0;
         advCurrent <= cca_pkg::ADV_OFF;
         vbusOn <= 1'b0;
         vconnCc1 <= 1'b0;
         vconnCc2 <= 1'b0;
         case (state_d)
            cca_pkg::ST_UDBG_SRC, cca_pkg::ST_ODBG_SRC: begin
               cc1PullUp <= 1'b1;
               cc2PullUp <= 1'b1;
               advCurrent <= adv3a0 ? cca_pkg::ADV_3A0 : cca_pkg::ADV_DEF;
               vbusOn <= 1'b1;
            end
            cca_pkg::ST_DBG_SNK: begin
               cc1PullDown <= 1'b1;
               cc2PullDown <= 1'b1;
            end
            // advertise on monitored pin; VCONN on other
            cca_pkg::ST_PWR_ACC: begin
               cc1PullUp <= !flipNext();
               cc2PullUp <= flipNext();
               advCurrent <= adv3a0 ? cca_pkg::ADV_3A0 : cca_pkg::ADV_1A5;
               vconnCc1 <= flipNext();
               vconnCc2 <= !flipNext();
            end
            cca_pkg::ST_UNSUP_ACC, cca_pkg::ST_VCONN_OFF: begin
               cc1PullUp <= !flip_q;
               cc2PullUp <= flip_q;
               advCurrent <= cca_pkg::ADV_DEF;
            end
            cca_pkg::ST_CT_UNATT: begin
               advCurrent <= cca_pkg::ADV_3A0;
            end
            default: begin
            end
         endcase
      end
   end

   function automatic logic flipNext();
      flipNext = (state_q == cca_pkg::ST_PWR_ACC) ? flip_q : (cc2Rd && !cc1Rd);
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         dbgCommonEn <= 1'b0;
         dbgOrientEn <= 1'b0;
         pdEnable <= 1'b0;
         pdSrcDfp <= 1'b0;
      end else begin
         dbgCommonEn <= state_q == cca_pkg::ST_UDBG_SRC ||
                        state_q == cca_pkg::ST_ODBG_SRC ||
                        state_q == cca_pkg::ST_DBG_SNK;
         dbgOrientEn <= state_q == cca_pkg::ST_ODBG_SRC;
         pdEnable <= (state_q == cca_pkg::ST_ODBG_SRC && vbusSafe5v) ||
                     state_q == cca_pkg::ST_PWR_ACC ||
                     state_q == cca_pkg::ST_CT_UNATT;
         pdSrcDfp <= state_q == cca_pkg::ST_ODBG_SRC ||
                     state_q == cca_pkg::ST_PWR_ACC;
      end
   end

   // isolation and 3.0 A pull-up; identity only; CT pull-downs
   always_ff @(posedge clk) begin
      if (rst) begin
         hostIsolate <= 1'b0;
         hostCcPullUp <= 1'b0;
         pdSopPrimeOnly <= 1'b0;
         ctCc1PullDown <= 1'b0;
         ctCc2PullDown <= 1'b0;
      end else begin
         hostIsolate <= state_d == cca_pkg::ST_CT_UNATT;
         hostCcPullUp <= state_d == cca_pkg::ST_CT_UNATT;
         pdSopPrimeOnly <= state_d == cca_pkg::ST_CT_UNATT;
         ctCc1PullDown <= state_d == cca_pkg::ST_CT_UNATT;
         ctCc2PullDown <= state_d == cca_pkg::ST_CT_UNATT;
      end
   end

   a_dbg_no_vconn: assert property (@(posedge clk) disable iff (rst)
      state_q == cca_pkg::ST_ODBG_SRC |=> !vconnCc1 && !vconnCc2)
      else $error("VCONN on in debug source");
   a_dbg_open_exit: assert property (@(posedge clk) disable iff (rst)
      (state_q == cca_pkg::ST_UDBG_SRC || state_q == cca_pkg::ST_ODBG_SRC) &&
      (cc1Open || cc2Open) |=> exitValid &&
      exitCode == ($past(isDrp) ? 3'h2 : 3'h1))
      else $error("Debug source open exit wrong");
   a_orient_en: assert property (@(posedge clk) disable iff (rst)
      dbgOrientEn |-> $past(state_q) == cca_pkg::ST_ODBG_SRC)
      else $error("Oriented debug enabled outside state");
   a_snk_vbus_exit: assert property (@(posedge clk) disable iff (rst)
      state_q == cca_pkg::ST_DBG_SNK && !vbusPresent |=> exitValid)
      else $error("Debug sink VBUS loss missed");
   a_pa_no_vbus: assert property (@(posedge clk) disable iff (rst)
      state_q == cca_pkg::ST_PWR_ACC |-> !vbusOn)
      else $error("VBUS driven in powered accessory");
   a_vconn_off: assert property (@(posedge clk) disable iff (rst)
      state_q == cca_pkg::ST_PWR_ACC && state_d == cca_pkg::ST_VCONN_OFF
      |=> ##[0:2] !vconnCc1 && !vconnCc2)
      else $error("VCONN not removed");
   a_ct_vconn: assert property (@(posedge clk) disable iff (rst)
      state_q == cca_pkg::ST_CT_UNATT && vconnLow |=>
      exitValid && exitCode == 3'h2)
      else $error("CT VCONN loss missed");
   a_ct_pulldn: assert property (@(posedge clk) disable iff (rst)
      state_q == cca_pkg::ST_CT_UNATT |-> ctCc1PullDown && ctCc2PullDown)
      else $error("CT pull-downs missing");
   a_ct_trans_bound: assert property (@(posedge clk) disable iff (rst)
      ctArmed_q |-> trCnt_q < DRP_TRANS_CYCLES[cca_pkg::CNT_W-1:0])
      else $error("CT unsupported exit late");
endmodule
`default_nettype wire

// ---- design/cca_pkg.sv ----
// Constants and types for the accessory attach state machine.
// Assumes a 100 MHz system clock and synchronous CC state decoders.
// Overview of operation
// - Debug source states: pull-ups on both CC, watch open, VBUS on, VCONN off.
// - Open on either CC in debug source: source-only to unattached source, else unattached sink.
// - Unoriented debug source moves to oriented when orientation required and detected.
// - Unoriented debug signals only after unoriented entry; oriented ones after oriented entry.
// - Oriented debug source: messaging only after entry and VBUS safe; source/downstream role.
// - Debug sink: VBUS and VCONN off, pull-downs on both CC, debug signals after entry.
// - Debug sink goes to unattached sink once VBUS is gone.
// - Powered accessory orientation latched only at entry from which CC shows sink termination.
// - Powered accessory advertises 1.5 A or 3.0 A on the sink-terminated CC and watches it.
// - Powered accessory turns VCONN on the unused CC within on time; never VBUS.
// - Powered accessory acts as messaging source, downstream data role.
// - Powered or unsupported accessory: monitored CC open goes to unattached sink.
// - Powered accessory goes to trial sink when partner is not a powered accessory.
// - Powered accessory without alternate mode by timeout goes to unsupported accessory.
// - Charge-through capable port goes to charge-through sink on matching identity report.
// - Leaving powered accessory turns VCONN off within off time; toward charge-through sink together with the exit report.
// - Unsupported accessory: default current on the sink-terminated CC, no VBUS or VCONN.
// - Charge-through unattached: isolate ports, host CC pull-up advertising 3.0 A.
// - Charge-through unattached answers only identity queries on the plug channel.
// - Charge-through unattached keeps pull-downs on both charge-through CC pins.
// - One charge-through CC with pull-up goes to await state; lost VCONN goes to unattached sink.
// - Both charge-through CC open for sink share goes to unsupported within transition time.
package cca_pkg;
   localparam int CLK_MHZ = 100;
   // Times in microseconds
   localparam int T_VCONN_ON_US = 2000;
   localparam int T_VCONN_OFF_US = 35;
   localparam int T_AME_TIMEOUT_US = 1000000;
   localparam int T_DRP_SNK_US = 35000;
   localparam int T_DRP_TRANS_US = 1000;
   // Derived cycle counts (exact products, longest fits in CNT_W bits)
   localparam int VCONN_ON_CYC = T_VCONN_ON_US * CLK_MHZ;
   localparam int VCONN_OFF_CYC = T_VCONN_OFF_US * CLK_MHZ;
   localparam int AME_CYC = T_AME_TIMEOUT_US * CLK_MHZ;
   localparam int DRP_SNK_CYC = T_DRP_SNK_US * CLK_MHZ;
   localparam int DRP_TRANS_CYC = T_DRP_TRANS_US * CLK_MHZ;
   localparam int CNT_W = 28;
   // Advertised current codes
   localparam logic [1:0] ADV_OFF = 2'h0;
   localparam logic [1:0] ADV_DEF = 2'h1;
   localparam logic [1:0] ADV_1A5 = 2'h2;
   localparam logic [1:0] ADV_3A0 = 2'h3;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_UDBG_SRC = 4'b0001,
      ST_ODBG_SRC = 4'b0010,
      ST_DBG_SNK = 4'b0011,
      ST_PWR_ACC = 4'b0100,
      ST_UNSUP_ACC = 4'b0101,
      ST_CT_UNATT = 4'b0110,
      ST_VCONN_OFF = 4'b0111
   } cca_state_t;

   // Exit codes toward the rest of the machine
   typedef enum logic [2:0] {
      EX_NONE = 3'b000,
      EX_UNATT_SRC = 3'b001,
      EX_UNATT_SNK = 3'b010,
      EX_TRY_SNK = 3'b011,
      EX_CT_UNATT_SNK = 3'b100,
      EX_CT_AWAIT = 3'b101,
      EX_CT_UNSUP = 3'b110
   } cca_exit_t;
endpackage

// ---- design/cca_timer.sv ----
// Single cycle down counter with load and expiry flag.
// Assumes load and the count value are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module cca_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [cca_pkg::CNT_W-1:0] count,
   input wire logic run,
   output logic expired
);
   logic [cca_pkg::CNT_W-1:0] cnt_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= count;
      end else if (run && cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || load) begin
         expired <= 1'b0;
      end else begin
         expired <= run && (cnt_q <= 1);
      end
   end
endmodule
`default_nettype wire

// ---- test/cca_attach_fsm_tb.sv ----
// Self-checking bench for the accessory attach state machine.
// Assumes short timer parameters 20, 10 and 5 cycles and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module cca_attach_fsm_tb;
   logic clk, rst, enterUdbgSrc, enterDbgSnk, enterPwrAcc, enterCtUnatt;
   logic isDrp, ctSupport, adv3a0, orientNeeded, orientFound, vbusPresent;
   logic vconnLow, notPwrAcc, altModeDone, ctIdentity, sopPrimeBusy;
   logic ctDirected, flip, cc1Open, cc2Open, cc1Rd, cc2Rd, vbusSafe5v;
   logic ctCc1Rp, ctCc2Rp, ctCc1Open, ctCc2Open, cc1PullUp, cc2PullUp;
   logic cc1PullDown, cc2PullDown, vbusOn, vconnCc1, vconnCc2, dbgCommonEn;
   logic dbgOrientEn, pdEnable, pdSrcDfp, pdSopPrimeOnly, hostIsolate;
   logic hostCcPullUp, ctCc1PullDown, ctCc2PullDown, flipped, exitValid;
   logic [1:0] kind, ctSrc, advCurrent;
   logic [2:0] exitCode;
   int num_errors = 0;
   int check_count = 0;

   cca_attach_fsm #(.AME_CYCLES(20), .DRP_SNK_CYCLES(10),
      .DRP_TRANS_CYCLES(5)) cca_attach_fsm_inst (.clk, .rst, .enterUdbgSrc,
      .enterDbgSnk, .enterPwrAcc, .enterCtUnatt, .isDrp, .ctSupport, .adv3a0,
      .cc1Open, .cc2Open, .cc1Rd, .cc2Rd, .ctCc1Rp, .ctCc2Rp, .ctCc1Open,
      .ctCc2Open, .orientNeeded, .orientFound, .vbusPresent, .vbusSafe5v,
      .vconnLow, .notPwrAcc, .altModeDone, .ctIdentity, .sopPrimeBusy,
      .ctDirected, .cc1PullUp, .cc2PullUp, .cc1PullDown, .cc2PullDown,
      .advCurrent, .vbusOn, .vconnCc1, .vconnCc2, .dbgCommonEn, .dbgOrientEn,
      .pdEnable, .pdSrcDfp, .pdSopPrimeOnly, .hostIsolate, .hostCcPullUp,
      .ctCc1PullDown, .ctCc2PullDown, .flipped, .exitCode, .exitValid);

   cca_far_model cca_far_model_inst (.clk, .rst, .kind, .flip, .ctSrc,
      .vbusOn, .ctCc1PullDown, .ctCc2PullDown, .cc1Open, .cc2Open, .cc1Rd,
      .cc2Rd, .vbusSafe5v, .ctCc1Rp, .ctCc2Rp, .ctCc1Open, .ctCc2Open);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic enter(input int which);
      @(posedge clk);
      enterUdbgSrc <= (which == 0);
      enterDbgSnk <= (which == 1);
      enterPwrAcc <= (which == 2);
      enterCtUnatt <= (which == 3);
      @(posedge clk);
      {enterUdbgSrc, enterDbgSnk, enterPwrAcc, enterCtUnatt} <= 4'h0;
      cyc(3);
   endtask

   // Waits for the exit pulse; vcExp is VCONN in the cycle before it
   task automatic wait_exit(input logic [2:0] code, input logic vcExp,
      input int bound, output int n);
      logic vcPrev;
      n = 0;
      #1;
      vcPrev = vconnCc1 | vconnCc2;
      while (exitValid !== 1'b1 && n < bound) begin
         vcPrev = vconnCc1 | vconnCc2;
         cyc(1);
         n++;
      end
      check("exit pulse", {7'h0, exitValid}, 8'h1);
      check("exit code", {5'h0, exitCode}, {5'h0, code});
      check("vconn before exit", {7'h0, vcPrev}, {7'h0, vcExp});
      @(posedge clk);
   endtask

   task automatic t_dbg_src(input logic drp);
      int n;
      @(posedge clk);
      isDrp <= drp;
      kind <= 2'h1;
      flip <= drp;
      orientNeeded <= 1'b0;
      orientFound <= 1'b1;
      enter(0);
      check("dbg src pins", {cc1PullUp, cc2PullUp, cc1PullDown, cc2PullDown,
         vbusOn, vconnCc1, vconnCc2, 1'b0}, 8'hc8);
      check("dbg src enables", {5'h0, dbgCommonEn, dbgOrientEn, pdEnable},
         8'h4);
      @(posedge clk);
      orientNeeded <= 1'b1;
      cyc(3);
      check("oriented enables", {6'h0, dbgCommonEn, dbgOrientEn},
         8'h3);
      check("pd before safe", {7'h0, pdEnable}, 8'h0);
      cyc(12);
      check("pd after safe", {6'h0, pdEnable, pdSrcDfp}, 8'h3);
      @(posedge clk);
      kind <= 2'h3;
      wait_exit(drp ? 3'h2 : 3'h1, 1'b0, 8, n);
      $display("done debug source drp=%0d", drp);
   endtask

   task automatic t_dbg_snk;
      int n;
      @(posedge clk);
      kind <= 2'h1;
      vbusPresent <= 1'b1;
      enter(1);
      check("dbg snk pins", {cc1PullUp, cc2PullUp, cc1PullDown, cc2PullDown,
         vbusOn, vconnCc1, vconnCc2, dbgCommonEn}, 8'h31);
      @(posedge clk);
      vbusPresent <= 1'b0;
      wait_exit(3'h2, 1'b0, 8, n);
      $display("done debug sink");
   endtask

   task automatic pa_enter(input logic fl, input logic a3);
      @(posedge clk);
      flip <= fl;
      kind <= 2'h2;
      adv3a0 <= a3;
      enter(2);
      check("pa orientation", {7'h0, flipped}, {7'h0, fl});
      check("pa advert", {6'h0, advCurrent},
         {6'h0, a3 ? cca_pkg::ADV_3A0 : cca_pkg::ADV_1A5});
      check("pa power", {4'h0, vbusOn, vconnCc1, vconnCc2,
         fl ? cc2PullUp : cc1PullUp}, {5'h0, fl, !fl, 1'b1});
      check("pa role", {6'h0, pdEnable, pdSrcDfp}, 8'h3);
   endtask

   task automatic t_pa_try;
      int n;
      pa_enter(1'b1, 1'b1);
      @(posedge clk);
      notPwrAcc <= 1'b1;
      wait_exit(3'h3, 1'b0, 8, n);
      notPwrAcc <= 1'b0;
      $display("done powered accessory rejected");
   endtask

   task automatic t_pa_open;
      int n;
      pa_enter(1'b0, 1'b0);
      @(posedge clk);
      kind <= 2'h0;
      wait_exit(3'h2, 1'b0, 8, n);
      $display("done powered accessory unplug");
   endtask

   task automatic t_pa_ame(input logic done);
      int n;
      @(posedge clk);
      altModeDone <= done;
      pa_enter(1'b0, 1'b0);
      cyc(12);
      check("before timeout", {6'h0, advCurrent}, 8'h2);
      cyc(10);
      check("after timeout", {2'h0, advCurrent, vconnCc1, vconnCc2, vbusOn,
         cc1PullUp}, done ? {2'h0, cca_pkg::ADV_1A5, 4'h5} :
         {2'h0, cca_pkg::ADV_DEF, 4'h1});
      @(posedge clk);
      kind <= 2'h0;
      wait_exit(3'h2, 1'b0, 8, n);
      $display("done alternate mode timeout done=%0d", done);
   endtask

   task automatic t_pa_ct;
      int n;
      @(posedge clk);
      ctSupport <= 1'b1;
      pa_enter(1'b0, 1'b1);
      @(posedge clk);
      ctIdentity <= 1'b1;
      sopPrimeBusy <= 1'b1;
      cyc(4);
      check("ct held busy", {6'h0, exitValid, vconnCc2}, 8'h1);
      @(posedge clk);
      sopPrimeBusy <= 1'b0;
      wait_exit(3'h4, 1'b1, 8, n);
      ctIdentity <= 1'b0;
      $display("done charge-through identity");
   endtask

   task automatic t_ct_await;
      int n;
      @(posedge clk);
      kind <= 2'h0;
      enter(3);
      check("ct terms", {hostIsolate, hostCcPullUp, ctCc1PullDown,
         ctCc2PullDown, pdSopPrimeOnly, vbusOn, vconnCc1, vconnCc2},
         8'hf8);
      check("ct advert", {6'h0, advCurrent}, {6'h0, cca_pkg::ADV_3A0});
      @(posedge clk);
      ctSrc <= 2'h2;
      wait_exit(3'h5, 1'b0, 8, n);
      ctSrc <= 2'h0;
      $display("done charge-through source");
   endtask

   task automatic t_ct_vconn;
      int n;
      enter(3);
      @(posedge clk);
      vconnLow <= 1'b1;
      wait_exit(3'h2, 1'b0, 8, n);
      vconnLow <= 1'b0;
      $display("done charge-through vconn loss");
   endtask

   task automatic t_ct_open;
      int n;
      enter(3);
      wait_exit(3'h6, 1'b0, 20, n);
      check("sink share wait", {7'h0, n >= 7 && n <= 12}, 8'h1);
      enter(3);
      @(posedge clk);
      ctDirected <= 1'b1;
      wait_exit(3'h6, 1'b0, 6, n);
      ctDirected <= 1'b0;
      $display("done charge-through unsupported");
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      $display("watchdog expired");
      final_report();
   end

   initial begin
      rst = 1'b1;
      {enterUdbgSrc, enterDbgSnk, enterPwrAcc, enterCtUnatt} = 4'h0;
      {isDrp, ctSupport, adv3a0, orientNeeded, orientFound} = 5'h0;
      {vbusPresent, vconnLow, notPwrAcc, altModeDone, ctIdentity} = 5'h0;
      {sopPrimeBusy, ctDirected, flip} = 3'h0;
      kind = 2'h0;
      ctSrc = 2'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      t_dbg_src(1'b0);
      t_dbg_src(1'b1);
      t_dbg_snk();
      t_pa_try();
      t_pa_open();
      t_pa_ame(1'b1);
      t_pa_ame(1'b0);
      t_pa_ct();
      t_ct_await();
      t_ct_vconn();
      t_ct_open();
      final_report();
   end
endmodule
`default_nettype wire

// ---- test/cca_far_model.sv ----
// Far side model: debug probe, powered accessory and charge-through source.
// Assumes the bench picks what is plugged in; CC decoders are ideal.
`timescale 1ns/100ps
`default_nettype none
module cca_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] kind,
   input wire logic flip,
   input wire logic [1:0] ctSrc,
   input wire logic vbusOn,
   input wire logic ctCc1PullDown,
   input wire logic ctCc2PullDown,
   output logic cc1Open,
   output logic cc2Open,
   output logic cc1Rd,
   output logic cc2Rd,
   output logic vbusSafe5v,
   output logic ctCc1Rp,
   output logic ctCc2Rp,
   output logic ctCc1Open,
   output logic ctCc2Open
);
   logic [3:0] ramp_q;
   logic rdA;
   logic rdB;
   logic openB;
   // Kind: 0 nothing, 1 Rd on both, 2 Rd and Ra, 3 Rd and open
   assign rdA = (kind != 2'h0);
   assign rdB = (kind == 2'h1);
   assign openB = (kind == 2'h3);
   assign cc1Rd = flip ? rdB : rdA;
   assign cc2Rd = flip ? rdA : rdB;
   assign cc1Open = !rdA || (flip && openB);
   assign cc2Open = !rdA || (!flip && openB);
   // VBUS takes 15 cycles to reach the safe level
   always_ff @(posedge clk) begin
      if (rst || !vbusOn) begin
         ramp_q <= 4'h0;
      end else if (ramp_q != 4'hf) begin
         ramp_q <= ramp_q + 4'h1;
      end
   end
   assign vbusSafe5v = (ramp_q == 4'hf);
   // Source on the charge-through side seen only through our Rd
   assign ctCc1Rp = ctSrc[0] && ctCc1PullDown;
   assign ctCc2Rp = ctSrc[1] && ctCc2PullDown;
   assign ctCc1Open = !ctSrc[0] && ctCc1PullDown;
   assign ctCc2Open = !ctSrc[1] && ctCc2PullDown;
endmodule
`default_nettype wire
